// file: design/brei_pkg.sv
// Shared constants for the boot ROM, serial EEPROM and strap interface.
// Assumes a single 20 MHz clock and a 32-bit APB register port.

package brei_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          RST_MIN_NS    = 800;
  localparam int          RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0]  RST_CNT_LAST  = 5'(RST_MIN_CYC - 1);

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CFG0      = 12'h000;
  localparam logic [11:0] REG_STRAP     = 12'h004;
  localparam logic [11:0] REG_PAGE      = 12'h008;
  localparam logic [11:0] REG_EECTL     = 12'h00C;
  localparam logic [11:0] REG_CTRL      = 12'h010;
  localparam logic [11:0] REG_EFF       = 12'h014;
  localparam logic [31:0] CTRL_RESET    = 32'h0000000C;
  localparam logic [7:0]  PAGE_RESET    = 8'h00;
  localparam logic [2:0]  EECTL_RESET   = 3'h0;
  localparam logic [15:0] STRAP_RESET   = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          CFG0_JUMPER   = 0;
  localparam int          CFG0_AUTOCFG  = 1;
  localparam int          CFG0_VALID    = 2;
  localparam int          CFG0_AUI      = 5;
  localparam int          EE_SEL        = 0;
  localparam int          EE_CLK        = 1;
  localparam int          EE_OUT        = 2;
  localparam int          EE_IN         = 3;
  localparam int          CTRL_PAGE     = 0;
  localparam int          CTRL_FLASH    = 1;
  localparam int          CTRL_CFG_LSB  = 2;
  localparam int          CTRL_AUTOCFG  = 16;
  localparam int          ST_ROM_LSB    = 0;
  localparam int          ST_MED_LSB    = 9;
  localparam int          ST_FORCE      = 14;
  localparam int          ST_JUMPER     = 15;
  localparam int          BD_EE_CLK     = 5;
  localparam int          BD_EE_OUT     = 6;
  localparam int          BD_EE_IN      = 7;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  SZ_16K        = 2'h0;
  localparam logic [1:0]  SZ_32K        = 2'h1;
  localparam logic [1:0]  SZ_64K        = 2'h2;
  localparam logic [1:0]  MED_COAX      = 2'h2;

  // Size in bits [1:0], base index in bits [4:2]; base is 0xC0000 plus index * 32K.
  function automatic logic rom_match(input logic [5:0] sa_hi, input logic [4:0] fld);
    logic [5:0] base;
    logic [5:0] mask;
    base = {2'h3, fld[4:2], 1'b0};
    mask = (fld[1:0] == SZ_16K) ? 6'h3F : (fld[1:0] == SZ_32K) ? 6'h3E : 6'h3C;
    return (fld[1:0] != 2'h3) && ((sa_hi & mask) == (base & mask));
  endfunction : rom_match

endpackage : brei_pkg

// file: design/brei_rst_filter.sv
// Glitch filter for the ISA bus reset.
// Assumes the ISA reset level is synchronous to mclk.
`timescale 1ns/100ps

module brei_rst_filter
  import brei_pkg::*;
(
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic isa_reset,
  output logic      active_q,
  output logic      fall
);

  logic [4:0] cnt_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 5'h00;
    end else if (!isa_reset) begin
      cnt_q <= 5'h00;
    end else if (cnt_q != RST_CNT_LAST) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // Short pulses never reach the active level and so never relatch straps.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      active_q <= 1'b0;
    end else begin
      active_q <= isa_reset && (active_q || cnt_q == RST_CNT_LAST);
    end
  end

  assign fall = active_q && !isa_reset;

  a_reset_accept: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(active_q) |-> $past(isa_reset) && cnt_q == RST_CNT_LAST)
    else $error("Reset accepted before the minimum width.");

endmodule : brei_rst_filter

// file: design/brei_rom_addr.sv
// ROM page address generator with first-read drive gating.
// Assumes drv_en is low until the straps have been captured.
`timescale 1ns/100ps

module brei_rom_addr
  import brei_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       drv_en,
  input  wire logic       page_mode,
  input  wire logic [7:0] page_reg,
  input  wire logic [1:0] rom_size,
  input  wire logic [1:0] sa_lo,
  input  wire logic       mem_read_n,
  output logic      [7:0] addr_q,
  output logic      [7:0] oe
);

  logic rd_prev_q;
  logic addr_en_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_prev_q <= 1'b1;
      addr_en_q <= 1'b0;
    end else begin
      rd_prev_q <= mem_read_n;
      if (!drv_en) begin
        addr_en_q <= 1'b0;
      end else if (rd_prev_q && !mem_read_n) begin
        addr_en_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addr_q <= 8'hFF;
    end else if (page_mode) begin
      addr_q <= page_reg;
    end else begin
      unique case (rom_size)
        SZ_32K:  addr_q <= {6'h00, 1'b1, sa_lo[0]};
        SZ_64K:  addr_q <= {6'h00, sa_lo};
        default: addr_q <= 8'h03;
      endcase
    end
  end

  // In normal mode the upper six lines are not used and stay undriven.
  assign oe = !(drv_en && addr_en_q) ? 8'h00 : (page_mode ? 8'hFF : 8'h03);

endmodule : brei_rom_addr

// file: design/brei_top.sv
// Boot ROM select, ROM page address, serial EEPROM pins and strap capture.
// Assumes ISA strobes and straps are synchronous to mclk and APB runs on mclk.
`timescale 1ns/100ps

module brei_top
  import brei_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        isa_reset,
  input  wire logic [5:0]  isa_addr_hi,
  input  wire logic        mem_read_n,
  input  wire logic        mem_write_n,
  output logic             rom_select_n,
  output logic             eeprom_select,
  input  wire logic [7:0]  rom_page_address_in,
  output logic      [7:0]  rom_page_address_out,
  output logic      [7:0]  rom_page_address_oe,
  input  wire logic [7:0]  rom_data_bus_in,
  output logic      [7:0]  rom_data_bus_out,
  output logic      [7:0]  rom_data_bus_oe,
  input  wire logic        jumper_mode_strap,
  input  wire logic        aui_detect,
  output logic             coax_medium_indicator
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic        rst_active;
  logic        rst_fall;
  logic [15:0] strap_smp_q;
  logic [15:0] strap_q;
  logic        strap_valid_q;
  logic        drv_en;
  logic [7:0]  page_q;
  logic [2:0]  ee_q;
  logic [31:0] ctrl_q;
  logic [31:0] prdata_q;
  logic        coax_q;
  logic        jumper;
  logic        autocfg;
  logic [13:0] eff_cfg;
  logic        rom_hit;
  logic        acc_wr;
  logic        addr_ok;
  logic [31:0] rd_mux;
  logic [15:0] pin_straps;
  logic        eeprom_serial_clock;
  logic        eeprom_serial_out;
  logic        eeprom_serial_in;

  // ----------------------------------------------------------------
  // Reset filter and strap capture
  // ----------------------------------------------------------------
  brei_rst_filter u_rst (
    .mclk      (mclk),
    .nrst      (nrst),
    .isa_reset (isa_reset),
    .active_q  (rst_active),
    .fall      (rst_fall)
  );

  // Strap pins are scattered over both shared buses; gather them into one field layout.
  assign pin_straps = {jumper_mode_strap, rom_page_address_in[7],
                       rom_data_bus_in[4], rom_data_bus_in[5], rom_data_bus_in[6],
                       rom_data_bus_in[7], rom_page_address_in[0],
                       rom_data_bus_in[0], rom_data_bus_in[1], rom_data_bus_in[2],
                       rom_data_bus_in[3],
                       rom_page_address_in[2], rom_page_address_in[3],
                       rom_page_address_in[4], rom_page_address_in[5],
                       rom_page_address_in[6]};

  // The sample taken on the last high cycle is the level at the falling edge.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      strap_smp_q <= STRAP_RESET;
    end else if (isa_reset) begin
      strap_smp_q <= pin_straps;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      strap_q       <= STRAP_RESET;
      strap_valid_q <= 1'b0;
    end else if (rst_fall) begin
      strap_q       <= strap_smp_q;
      strap_valid_q <= 1'b1;
    end else if (rst_active) begin
      strap_valid_q <= 1'b0;
    end
  end

  // Drivers also stay off during an unaccepted pulse, so strap resistors are never fought.
  assign drv_en = strap_valid_q && !rst_active && !isa_reset;

  // ----------------------------------------------------------------
  // Effective configuration
  // ----------------------------------------------------------------
  assign jumper  = strap_q[ST_JUMPER];
  assign autocfg = !jumper && (strap_q[ST_FORCE] || ctrl_q[CTRL_AUTOCFG]);
  assign eff_cfg = jumper ? strap_q[13:0] : ctrl_q[CTRL_CFG_LSB +: 14];

  // ----------------------------------------------------------------
  // Boot ROM select and page address
  // ----------------------------------------------------------------
  assign rom_hit = rom_match(isa_addr_hi, eff_cfg[ST_ROM_LSB +: 5]);

  always_comb begin
    rom_select_n = 1'b1;
    if (drv_en && rom_hit && !mem_read_n) begin
      rom_select_n = 1'b0;
    end else if (drv_en && rom_hit && !mem_write_n && ctrl_q[CTRL_FLASH]) begin
      rom_select_n = 1'b0;
    end
  end

  brei_rom_addr u_addr (
    .mclk       (mclk),
    .nrst       (nrst),
    .drv_en     (drv_en),
    .page_mode  (ctrl_q[CTRL_PAGE]),
    .page_reg   (page_q),
    .rom_size   (eff_cfg[ST_ROM_LSB +: 2]),
    .sa_lo      (isa_addr_hi[1:0]),
    .mem_read_n (mem_read_n),
    .addr_q     (rom_page_address_out),
    .oe         (rom_page_address_oe)
  );

  // ----------------------------------------------------------------
  // Serial EEPROM pins
  // ----------------------------------------------------------------
  // Software bit-bangs the serial protocol; clock and data change only on its writes or when an accepted ISA reset clears them.
  assign eeprom_select       = ee_q[EE_SEL];
  assign eeprom_serial_clock = ee_q[EE_CLK];
  assign eeprom_serial_out   = ee_q[EE_OUT];
  assign eeprom_serial_in    = rom_data_bus_in[BD_EE_IN];

  always_comb begin
    rom_data_bus_out            = 8'h00;
    rom_data_bus_oe             = 8'h00;
    rom_data_bus_out[BD_EE_CLK] = eeprom_serial_clock;
    rom_data_bus_out[BD_EE_OUT] = eeprom_serial_out;
    rom_data_bus_oe[BD_EE_CLK]  = drv_en && ee_q[EE_SEL];
    rom_data_bus_oe[BD_EE_OUT]  = drv_en && ee_q[EE_SEL];
  end

  // ----------------------------------------------------------------
  // Medium indicator
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      coax_q <= 1'b0;
    end else begin
      coax_q <= !aui_detect && eff_cfg[ST_MED_LSB +: 2] == MED_COAX;
    end
  end

  assign coax_medium_indicator = coax_q;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign addr_ok = paddr[1:0] == 2'h0 && paddr <= REG_EFF;
  assign acc_wr  = psel && penable && pwrite && addr_ok;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = prdata_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      page_q <= PAGE_RESET;
      ctrl_q <= CTRL_RESET;
    end else if (acc_wr && paddr == REG_PAGE) begin
      page_q <= pwdata[7:0];
    end else if (acc_wr && paddr == REG_CTRL) begin
      ctrl_q <= {15'h0000, pwdata[16:0]};
    end
  end

  // An accepted ISA reset ends any EEPROM access in progress.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ee_q <= EECTL_RESET;
    end else if (rst_active) begin
      ee_q <= EECTL_RESET;
    end else if (acc_wr && paddr == REG_EECTL) begin
      ee_q <= pwdata[2:0];
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (paddr)
      REG_CFG0: begin
        rd_mux[CFG0_JUMPER]  = jumper;
        rd_mux[CFG0_AUTOCFG] = autocfg;
        rd_mux[CFG0_VALID]   = strap_valid_q;
        rd_mux[CFG0_AUI]     = aui_detect;
      end
      REG_STRAP: rd_mux = {16'h0000, strap_q};
      REG_PAGE:  rd_mux = {24'h000000, page_q};
      REG_EECTL: rd_mux = {28'h0000000, eeprom_serial_in, ee_q};
      REG_CTRL:  rd_mux = ctrl_q;
      REG_EFF:   rd_mux = {18'h00000, eff_cfg};
      default:   rd_mux = 32'h00000000;
    endcase
  end

  // Read data is fetched in the setup cycle so that it comes from a flop with no wait.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_rom_read_sel: assert property (
    drv_en && rom_hit && !mem_read_n |-> !rom_select_n)
    else $error("ROM select missing on matched read.");

  a_rom_write_gate: assert property (
    mem_read_n && !ctrl_q[CTRL_FLASH] |-> rom_select_n)
    else $error("ROM select on write with flash disabled.");

  a_eeprom_pins: assert property (
    rom_data_bus_oe[BD_EE_CLK] |-> eeprom_select && !rom_data_bus_oe[BD_EE_IN])
    else $error("EEPROM pins driven outside an access.");

  a_strap_capture: assert property (
    $fell(rst_active) |-> strap_q == $past(strap_smp_q) && strap_valid_q)
    else $error("Straps not captured at reset fall.");

  a_force_autocfg: assert property (
    strap_valid_q && !strap_q[ST_JUMPER] && strap_q[ST_FORCE] |-> autocfg)
    else $error("Force strap did not select autoconfig.");

  a_jumperless_cfg: assert property (
    !jumper |-> eff_cfg == ctrl_q[CTRL_CFG_LSB +: 14])
    else $error("Strap field used in jumperless mode.");

  a_page_drive: assert property (
    ctrl_q[CTRL_PAGE] && $stable(ctrl_q) && $stable(page_q) && rom_page_address_oe[7]
      |-> rom_page_address_out == page_q)
    else $error("Page address differs from page register.");

  a_addr_first_read: assert property (
    $rose(drv_en) |-> rom_page_address_oe == 8'h00
      ##1 (rom_page_address_oe == 8'h00 || !$past(mem_read_n)))
    else $error("Address lines driven before a read strobe fall.");

  a_aui_indicator: assert property (
    aui_detect ##1 aui_detect |-> !coax_medium_indicator)
    else $error("Coax indicator high with AUI detected.");

  a_pins_quiet: assert property (
    isa_reset || !strap_valid_q |-> rom_page_address_oe == 8'h00 && rom_data_bus_oe == 8'h00)
    else $error("Shared pins driven during reset.");

  a_rom_write_sel: assert property (
    drv_en && rom_hit && !mem_write_n && ctrl_q[CTRL_FLASH] |-> !rom_select_n)
    else $error("ROM select missing on enabled flash write.");

  a_select_quiet: assert property (
    !drv_en |-> rom_select_n)
    else $error("ROM select driven before straps were captured.");

  a_eeprom_reset: assert property (
    rst_active |=> !eeprom_select)
    else $error("EEPROM select held through an ISA reset.");

  a_eeprom_in_read: assert property (
    psel && !penable && !pwrite && paddr == REG_EECTL
      |=> prdata[EE_IN] == $past(eeprom_serial_in))
    else $error("EEPROM data in not returned on read.");

  a_jumper_mode: assert property (
    rst_fall |=> jumper == $past(strap_smp_q[ST_JUMPER]))
    else $error("Mode strap not taken at reset fall.");

  a_jumper_cfg: assert property (
    jumper |-> eff_cfg == strap_q[13:0])
    else $error("Strap fields not used in jumper mode.");

  a_size_16k: assert property (
    !$past(ctrl_q[CTRL_PAGE]) && $past(eff_cfg[ST_ROM_LSB +: 2]) == SZ_16K
      |-> rom_page_address_out[1:0] == 2'h3)
    else $error("Address lines wrong for the smallest ROM.");

  a_size_32k: assert property (
    !$past(ctrl_q[CTRL_PAGE]) && $past(eff_cfg[ST_ROM_LSB +: 2]) == SZ_32K
      |-> rom_page_address_out[1:0] == {1'b1, $past(isa_addr_hi[0])})
    else $error("Address lines wrong for the middle ROM size.");

  a_size_64k: assert property (
    !$past(ctrl_q[CTRL_PAGE]) && $past(eff_cfg[ST_ROM_LSB +: 2]) == SZ_64K
      |-> rom_page_address_out[1:0] == $past(isa_addr_hi[1:0]))
    else $error("Address lines wrong for the largest ROM.");

  a_addr_after_read: assert property (
    rom_page_address_oe != 8'h00 && $past(rom_page_address_oe) == 8'h00
      |-> !$past(mem_read_n))
    else $error("Address lines driven without a read strobe fall.");

  a_aui_flag: assert property (
    psel && !penable && !pwrite && paddr == REG_CFG0
      |=> prdata[CFG0_AUI] == $past(aui_detect))
    else $error("AUI flag does not follow the detect input.");

endmodule : brei_top

// file: testbench/brei_board_model.sv
// Board model: strap resistors, boot ROM pins and the serial EEPROM data line.
// Assumes the device raises an output enable only while it drives that pin.
`timescale 1ns/100ps

module brei_board_model (
  input  wire logic [7:0] strap_ba,
  input  wire logic [7:0] strap_bd,
  input  wire logic       ee_bit,
  input  wire logic       eeprom_select,
  input  wire logic [7:0] addr_out,
  input  wire logic [7:0] addr_oe,
  input  wire logic [7:0] data_out,
  input  wire logic [7:0] data_oe,
  output logic      [7:0] addr_in,
  output logic      [7:0] data_in
);
  logic [7:0] bd_pull;

  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  // Released pins settle to their strap resistors, except data bit 7, which follows ee_bit while selected; never to the last driven value.
  always_comb begin
    bd_pull    = strap_bd;
    bd_pull[7] = eeprom_select ? ee_bit : strap_bd[7];
    addr_in    = (addr_oe & addr_out) | (~addr_oe & strap_ba);
    data_in    = (data_oe & data_out) | (~data_oe & bd_pull);
  end
endmodule : brei_board_model

// file: testbench/test_boot_rom_eeprom_strap_interface.sv
// Testbench for the boot ROM, serial EEPROM and strap interface.
// Assumes the design package and the board model are compiled first.
`timescale 1ns/100ps

module test_boot_rom_eeprom_strap_interface;
  import brei_pkg::*;

  logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, rd_err;
  logic        isa_reset, mem_read_n, mem_write_n, jumper_mode_strap;
  logic        aui_detect, ee_bit, rom_select_n, eeprom_select, coax_medium_indicator;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [5:0]  isa_addr_hi;
  logic [7:0]  ba_in, ba_out, ba_oe, bd_in, bd_out, bd_oe, strap_ba, strap_bd;
  int          num_errors, comparisons, cycles;

  brei_top dut_u (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .isa_reset(isa_reset), .isa_addr_hi(isa_addr_hi),
    .mem_read_n(mem_read_n), .mem_write_n(mem_write_n), .rom_select_n(rom_select_n),
    .eeprom_select(eeprom_select), .rom_page_address_in(ba_in),
    .rom_page_address_out(ba_out), .rom_page_address_oe(ba_oe), .rom_data_bus_in(bd_in),
    .rom_data_bus_out(bd_out), .rom_data_bus_oe(bd_oe),
    .jumper_mode_strap(jumper_mode_strap), .aui_detect(aui_detect),
    .coax_medium_indicator(coax_medium_indicator));

  brei_board_model board_u (.strap_ba(strap_ba), .strap_bd(strap_bd), .ee_bit(ee_bit),
    .eeprom_select(eeprom_select), .addr_out(ba_out), .addr_oe(ba_oe),
    .data_out(bd_out), .data_oe(bd_oe), .addr_in(ba_in), .data_in(bd_in));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  always #25 mclk = ~mclk;

  // The whole run needs well under a thousand cycles.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0, rd_q, rd_err);
    chk(what, rd_q, exp);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd_q, rd_err);
  endtask : wr

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic isa(input logic [5:0] a, input logic r_n, input logic w_n);
    @(posedge mclk);
    isa_addr_hi <= a;
    mem_read_n  <= r_n;
    mem_write_n <= w_n;
    #1;
  endtask : isa

  task automatic isa_rst(input int n);
    @(posedge mclk);
    isa_reset <= 1'b1;
    step(n / 2);
    chk("oe in isa reset", 32'({ba_oe, bd_oe}), 32'h0);
    repeat (n - n / 2) @(posedge mclk);
    isa_reset <= 1'b0;
    step(4);
  endtask : isa_rst

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0; nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; isa_reset = 1'b0; isa_addr_hi = 6'h00;
    mem_read_n = 1'b1; mem_write_n = 1'b1; ee_bit = 1'b1;
    aui_detect = 1'b0;
    strap_ba = 8'h10; strap_bd = 8'h81; jumper_mode_strap = 1'b1;
    num_errors = 0; comparisons = 0; cycles = 0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    step(2);
    chk("select idle", 32'(rom_select_n), 32'h1);
    chk("oe after reset", 32'({ba_oe, bd_oe}), 32'h0);
    rd(REG_CFG0, 32'h0, "config zero");
    $display("test reset done");
    isa_rst(15);
    rd(REG_STRAP, 32'h0, "strap short pulse");
    isa_rst(18);
    rd(REG_STRAP, 32'h8504, "strap");
    rd(REG_CFG0, 32'h5, "config zero");
    rd(REG_EFF, 32'h0504, "effective");
    aui_detect <= 1'b1;
    #1;
    chk("coax", 32'(coax_medium_indicator), 32'h1);
    step(2);
    chk("coax aui", 32'(coax_medium_indicator), 32'h0);
    rd(REG_CFG0, 32'h25, "config zero aui");
    aui_detect <= 1'b0;
    $display("test straps done");
    isa(6'h32, 1'b1, 1'b0);
    chk("select write", 32'(rom_select_n), 32'h1);
    chk("address oe", 32'(ba_oe), 32'h0);
    isa(6'h32, 1'b0, 1'b1);
    chk("select read", 32'(rom_select_n), 32'h0);
    step(1);
    chk("address oe", 32'(ba_oe), 32'h03);
    chk("address 16k", 32'(ba_out & 8'h03), 32'h03);
    isa(6'h33, 1'b0, 1'b1);
    chk("select miss", 32'(rom_select_n), 32'h1);
    isa(6'h32, 1'b1, 1'b1);
    chk("select idle", 32'(rom_select_n), 32'h1);
    wr(REG_CTRL, 32'h0000000E);
    isa(6'h32, 1'b1, 1'b0);
    chk("select flash", 32'(rom_select_n), 32'h0);
    isa(6'h32, 1'b1, 1'b1);
    wr(REG_PAGE, 32'h000000A5);
    wr(REG_CTRL, 32'h0000000F);
    step(2);
    chk("page address", 32'(ba_out), 32'hA5);
    chk("page oe", 32'(ba_oe), 32'hFF);
    $display("test rom done");
    wr(REG_EECTL, 32'h7);
    step(1);
    chk("eeprom select", 32'(eeprom_select), 32'h1);
    chk("eeprom pins", 32'({bd_oe[6:5], bd_out[6:5]}), 32'hF);
    rd(REG_EECTL, 32'hF, "eeprom in high");
    ee_bit <= 1'b0;
    rd(REG_EECTL, 32'h7, "eeprom in low");
    wr(REG_EECTL, 32'h2);
    step(1);
    chk("eeprom idle", 32'({eeprom_select, bd_out[5]}), 32'h1);
    $display("test eeprom done");
    @(posedge mclk);
    jumper_mode_strap <= 1'b0;
    strap_ba <= 8'h90;
    isa_rst(18);
    rd(REG_CFG0, 32'h6, "config zero forced");
    wr(REG_CTRL, 32'h00001218);
    rd(REG_EFF, 32'h0486, "effective jumperless");
    isa(6'h31, 1'b0, 1'b1);
    chk("select 64k", 32'(rom_select_n), 32'h0);
    step(1);
    chk("address 64k", 32'(ba_out & 8'h03), 32'h01);
    isa(6'h31, 1'b1, 1'b1);
    apb(1'b0, 12'h020, 32'h0, rd_q, rd_err);
    chk("unmapped error", 32'(rd_err), 32'h1);
    chk("unmapped data", rd_q, 32'h0);
    $display("test jumperless done");
    test_done();
  end
endmodule : test_boot_rom_eeprom_strap_interface
